/* File: edg_dbuf_reg.sv */
// one double-buffered register: software shadow copy and processing active copy
`timescale 1ns/1ps
module edg_dbuf_reg
    import edg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_clear,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wstrb,
    input wire logic [31:0] i_wdata,
    input wire logic i_commit,
    output logic [31:0] o_shadow,
    output logic [31:0] o_active
);

    // shadow copy takes bus writes at once
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_shadow <= EDG_DBUF_RST;
        end else if (i_ce) begin
            if (i_clear) begin
                o_shadow <= EDG_DBUF_RST;
            end else if (i_wr_en) begin
                o_shadow <= edg_merge(o_shadow, i_wdata, i_wstrb);
            end
        end
    end

    // active copy loads only on a committed frame start
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_active <= EDG_DBUF_RST;
        end else if (i_ce) begin
            if (i_clear) begin
                o_active <= EDG_DBUF_RST;
            end else if (i_commit) begin
                o_active <= o_shadow;
            end
        end
    end

endmodule

/* File: edg_pkg.sv */
// package with register map, field layout and helpers for the edge gain register bank
package edg_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam int EDG_ADDR_W = 9;
    localparam logic [8:0] EDG_OFF_CONTROL = 9'h000;
    localparam logic [8:0] EDG_OFF_STATE = 9'h004;
    localparam logic [8:0] EDG_OFF_FAULT = 9'h008;
    localparam logic [8:0] EDG_OFF_MASK = 9'h00C;
    localparam logic [8:0] EDG_OFF_REVISION = 9'h010;
    localparam logic [8:0] EDG_OFF_DIAG0 = 9'h014;
    localparam logic [8:0] EDG_OFF_DIAG1 = 9'h018;
    localparam logic [8:0] EDG_OFF_DIAG2 = 9'h01C;
    localparam logic [8:0] EDG_OFF_FRAME_DIM = 9'h020;
    localparam logic [8:0] EDG_OFF_GAIN_H = 9'h100;
    localparam logic [8:0] EDG_OFF_GAIN_V = 9'h104;
    localparam logic [8:0] EDG_OFF_GAIN_D = 9'h108;
    localparam logic [8:0] EDG_OFF_GAIN_2ND = 9'h10C;

    // ------------------------------------------------------------
    // control fields and reset values
    // ------------------------------------------------------------
    localparam int EDG_CTRL_ENABLE_BIT = 0;
    localparam int EDG_CTRL_COMMIT_BIT = 1;
    localparam int EDG_CTRL_SRST_BIT = 30;
    localparam logic [31:0] EDG_CONTROL_RST = 32'h0000_0002;
    localparam logic [31:0] EDG_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] EDG_FAULT_RST = 32'h0000_0000;
    localparam logic [31:0] EDG_DBUF_RST = 32'h0000_0000;
    localparam logic [31:0] EDG_REVISION_VAL = 32'h0001_0000; // arbitrary value
    localparam int EDG_DBUF_N = 5;
    localparam logic [1:0] EDG_RESP_OKAY = 2'h0;
    localparam logic [1:0] EDG_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // register select
    // ------------------------------------------------------------
    typedef enum {
        EDG_SEL_CONTROL, EDG_SEL_STATE, EDG_SEL_FAULT, EDG_SEL_MASK, EDG_SEL_REVISION,
        EDG_SEL_DIAG0, EDG_SEL_DIAG1, EDG_SEL_DIAG2,
        EDG_SEL_FRAME_DIM, EDG_SEL_GAIN_H, EDG_SEL_GAIN_V, EDG_SEL_GAIN_D, EDG_SEL_GAIN_2ND,
        EDG_SEL_NONE
    } edg_sel_t;

    // decode a byte address into a register select
    function automatic edg_sel_t edg_decode(input logic [8:0] addr);
        case (addr)
            EDG_OFF_CONTROL: edg_decode = EDG_SEL_CONTROL;
            EDG_OFF_STATE: edg_decode = EDG_SEL_STATE;
            EDG_OFF_FAULT: edg_decode = EDG_SEL_FAULT;
            EDG_OFF_MASK: edg_decode = EDG_SEL_MASK;
            EDG_OFF_REVISION: edg_decode = EDG_SEL_REVISION;
            EDG_OFF_DIAG0: edg_decode = EDG_SEL_DIAG0;
            EDG_OFF_DIAG1: edg_decode = EDG_SEL_DIAG1;
            EDG_OFF_DIAG2: edg_decode = EDG_SEL_DIAG2;
            EDG_OFF_FRAME_DIM: edg_decode = EDG_SEL_FRAME_DIM;
            EDG_OFF_GAIN_H: edg_decode = EDG_SEL_GAIN_H;
            EDG_OFF_GAIN_V: edg_decode = EDG_SEL_GAIN_V;
            EDG_OFF_GAIN_D: edg_decode = EDG_SEL_GAIN_D;
            EDG_OFF_GAIN_2ND: edg_decode = EDG_SEL_GAIN_2ND;
            default: edg_decode = EDG_SEL_NONE;
        endcase
    endfunction

    // merge write data into an old word by byte strobes
    function automatic logic [31:0] edg_merge(input logic [31:0] old, input logic [31:0] wdata,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

/* File: edg_regs.sv */
// control register bank with double-buffered gains and frame size behind an axi4-lite slave
`timescale 1ns/1ps
module edg_regs
    import edg_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic [8:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [8:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire logic i_sof_beat,
    input wire logic [31:0] i_core_state,
    input wire logic [31:0] i_fault_set,
    input wire logic [31:0] i_diag_0,
    input wire logic [31:0] i_diag_1,
    input wire logic [31:0] i_diag_2,
    output logic o_core_enable,
    output logic o_soft_reset,
    output logic [31:0] o_frame_dimensions,
    output logic [31:0] o_horizontal_edge_gain,
    output logic [31:0] o_vertical_edge_gain,
    output logic [31:0] o_diagonal_edge_gain,
    output logic [31:0] o_second_derivative_gain
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    localparam edg_sel_t DBUF_SEL [EDG_DBUF_N] = '{EDG_SEL_FRAME_DIM, EDG_SEL_GAIN_H, EDG_SEL_GAIN_V,
                                                  EDG_SEL_GAIN_D, EDG_SEL_GAIN_2ND};
    logic [31:0] control_reg;
    logic [31:0] mask_reg;
    logic [31:0] fault_reg;
    logic [31:0] shadow [EDG_DBUF_N];
    logic [31:0] active [EDG_DBUF_N];
    logic [31:0] rd_next;
    edg_sel_t wr_sel;
    edg_sel_t rd_sel;
    logic wr_fire;
    logic rd_fire;
    logic srst;
    logic commit;

    assign wr_sel = edg_decode(i_s_axi_awaddr);
    assign rd_sel = edg_decode(i_s_axi_araddr);
    assign wr_fire = i_ce && o_s_axi_awready; // both channels taken this edge
    assign rd_fire = i_ce && o_s_axi_arready;
    assign srst = control_reg[EDG_CTRL_SRST_BIT];
    // frame start loads active set only with the flag up
    assign commit = i_sof_beat && control_reg[EDG_CTRL_COMMIT_BIT] && !srst;

    // ------------------------------------------------------------
    // write channel handshake
    // ------------------------------------------------------------
    // address and data accepted together, one beat at a time
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= EDG_RESP_OKAY;
        end else if (i_ce) begin
            o_s_axi_awready <= i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready && !o_s_axi_bvalid;
            o_s_axi_wready <= i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready && !o_s_axi_bvalid;
            if (o_s_axi_awready) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= (wr_sel == EDG_SEL_NONE) ? EDG_RESP_SLVERR : EDG_RESP_OKAY;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    // read mux: double-buffered registers show the shadow copy
    always_comb begin
        case (rd_sel)
            EDG_SEL_CONTROL: rd_next = control_reg;
            EDG_SEL_STATE: rd_next = i_core_state;
            EDG_SEL_FAULT: rd_next = fault_reg;
            EDG_SEL_MASK: rd_next = mask_reg;
            EDG_SEL_REVISION: rd_next = EDG_REVISION_VAL;
            EDG_SEL_DIAG0: rd_next = i_diag_0;
            EDG_SEL_DIAG1: rd_next = i_diag_1;
            EDG_SEL_DIAG2: rd_next = i_diag_2;
            EDG_SEL_FRAME_DIM: rd_next = shadow[0];
            EDG_SEL_GAIN_H: rd_next = shadow[1];
            EDG_SEL_GAIN_V: rd_next = shadow[2];
            EDG_SEL_GAIN_D: rd_next = shadow[3];
            EDG_SEL_GAIN_2ND: rd_next = shadow[4];
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // read address accept and data return
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= EDG_RESP_OKAY;
        end else if (i_ce) begin
            o_s_axi_arready <= i_s_axi_arvalid && !o_s_axi_arready && !o_s_axi_rvalid;
            if (o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_next;
                o_s_axi_rresp <= (rd_sel == EDG_SEL_NONE) ? EDG_RESP_SLVERR : EDG_RESP_OKAY;
            end else if (i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // plain registers
    // ------------------------------------------------------------
    // control: soft reset bit survives its own reset so software can release it
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            control_reg <= EDG_CONTROL_RST;
        end else if (i_ce) begin
            if (wr_fire && wr_sel == EDG_SEL_CONTROL) begin
                control_reg <= edg_merge(control_reg, i_s_axi_wdata, i_s_axi_wstrb);
            end else if (srst) begin
                control_reg <= EDG_CONTROL_RST | (32'h0000_0001 << EDG_CTRL_SRST_BIT);
            end
        end
    end

    // interrupt mask storage
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            mask_reg <= EDG_MASK_RST;
        end else if (i_ce) begin
            if (srst) begin
                mask_reg <= EDG_MASK_RST;
            end else if (wr_fire && wr_sel == EDG_SEL_MASK) begin
                mask_reg <= edg_merge(mask_reg, i_s_axi_wdata, i_s_axi_wstrb);
            end
        end
    end

    // sticky faults, write one to clear, a new event wins over its clear
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fault_reg <= EDG_FAULT_RST;
        end else if (i_ce) begin
            if (srst) begin
                fault_reg <= EDG_FAULT_RST | i_fault_set;
            end else if (wr_fire && wr_sel == EDG_SEL_FAULT) begin
                fault_reg <= (fault_reg & ~edg_merge(32'h0000_0000, i_s_axi_wdata, i_s_axi_wstrb)) | i_fault_set;
            end else begin
                fault_reg <= fault_reg | i_fault_set;
            end
        end
    end

    // ------------------------------------------------------------
    // double-buffered set
    // ------------------------------------------------------------
    // one shadow/active pair per register, all sharing one commit
    for (genvar g = 0; g < EDG_DBUF_N; g++) begin : g_dbuf
        edg_dbuf_reg u_dbuf (
            .i_ref_clk(i_ref_clk),
            .i_resetn(i_resetn),
            .i_ce(i_ce),
            .i_clear(srst),
            .i_wr_en(wr_fire && wr_sel == DBUF_SEL[g]),
            .i_wstrb(i_s_axi_wstrb),
            .i_wdata(i_s_axi_wdata),
            .i_commit(commit),
            .o_shadow(shadow[g]),
            .o_active(active[g])
        );
    end

    // outputs straight from the active flops and control flops
    assign o_frame_dimensions = active[0];
    assign o_horizontal_edge_gain = active[1];
    assign o_vertical_edge_gain = active[2];
    assign o_diagonal_edge_gain = active[3];
    assign o_second_derivative_gain = active[4];
    assign o_core_enable = control_reg[EDG_CTRL_ENABLE_BIT];
    assign o_soft_reset = control_reg[EDG_CTRL_SRST_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_write_gain_v;
        wr_fire && wr_sel == EDG_SEL_GAIN_V && i_s_axi_wstrb == 4'hF && !srst && !commit;
    endsequence

    sequence s_flag_low_frame;
        i_ce && i_sof_beat && !control_reg[EDG_CTRL_COMMIT_BIT] && !srst;
    endsequence

    shadow_write_a: assert property (s_write_gain_v |=> shadow[2] == $past(i_s_axi_wdata))
        else $error("shadow not written at once");
    two_copies_a: assert property (s_write_gain_v |=> o_vertical_edge_gain == $past(o_vertical_edge_gain))
        else $error("active copy changed on a bus write");
    commit_copy_a: assert property (i_ce && commit |=> o_horizontal_edge_gain == $past(shadow[1]))
        else $error("active not loaded at frame start");
    flag_hold_a: assert property (s_flag_low_frame |=> $stable(o_diagonal_edge_gain) && $stable(o_frame_dimensions))
        else $error("active changed with commit flag low");
    commit_all_a: assert property (i_ce && commit |=> o_frame_dimensions == $past(shadow[0])
                                   && o_second_derivative_gain == $past(shadow[4]))
        else $error("double-buffered values not committed together");
    // response must appear, then still stand one cycle later unless bready was seen
    write_resp_a: assert property (wr_fire |=> o_s_axi_bvalid ##1 (o_s_axi_bvalid || $past(i_s_axi_bready)))
        else $error("write response missing or dropped early");
    read_shadow_a: assert property (rd_fire && rd_sel == EDG_SEL_GAIN_D |=> o_s_axi_rvalid
                                    && o_s_axi_rdata == $past(shadow[3]))
        else $error("read did not return shadow value");
    // a control write in the same cycle may release the soft reset, so it is left out
    soft_reset_a: assert property (i_ce && srst && !(wr_fire && wr_sel == EDG_SEL_CONTROL)
                                   |=> shadow[3] == EDG_DBUF_RST && o_diagonal_edge_gain == EDG_DBUF_RST
                                   && o_soft_reset && mask_reg == EDG_MASK_RST)
        else $error("soft reset did not restore registers");

endmodule

/* File: edg_regs_test.sv */
// self-checking testbench for the edge gain register bank
`timescale 1ns/1ps
module edg_regs_test;
    import edg_pkg::*;

    logic i_ref_clk, i_resetn, i_ce, i_sof_beat;
    logic [8:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic [31:0] i_s_axi_wdata;
    logic [3:0] i_s_axi_wstrb;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic [31:0] o_s_axi_rdata;
    logic [31:0] i_core_state, i_fault_set, i_diag_0, i_diag_1, i_diag_2;
    logic o_core_enable, o_soft_reset;
    logic [31:0] act [5];
    int err_total = 0;
    int comparisons = 0;
    logic [8:0] offs [5] = '{EDG_OFF_FRAME_DIM, EDG_OFF_GAIN_H, EDG_OFF_GAIN_V, EDG_OFF_GAIN_D, EDG_OFF_GAIN_2ND};
    logic [31:0] vals [5] = '{32'h0438_0780, 32'h0000_0040, 32'h0000_0021, 32'h0000_0012, 32'h0000_0007};
    logic [31:0] zer [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    edg_regs edg_regs_i (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce),
        .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
        .i_s_axi_wdata(i_s_axi_wdata), .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
        .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
        .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
        .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
        .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready), .i_sof_beat(i_sof_beat),
        .i_core_state(i_core_state), .i_fault_set(i_fault_set), .i_diag_0(i_diag_0), .i_diag_1(i_diag_1),
        .i_diag_2(i_diag_2), .o_core_enable(o_core_enable), .o_soft_reset(o_soft_reset),
        .o_frame_dimensions(act[0]), .o_horizontal_edge_gain(act[1]), .o_vertical_edge_gain(act[2]),
        .o_diagonal_edge_gain(act[3]), .o_second_derivative_gain(act[4])
    );

    // ------------------------------------------------------------
    // clock and shared tasks
    // ------------------------------------------------------------
    // free-running 100 MHz core clock
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // print counts and the verdict, then stop
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // compare one value and report at once on a difference
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one write: hold address and data until awready is seen, then take bresp with bready held high
    task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_wstrb <= s;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        // a hang here is caught by the watchdog
        do @(posedge i_ref_clk); while (o_s_axi_awready !== 1'b1);
        chk({31'h0, o_s_axi_wready}, 32'h1, "write data ready");
        i_s_axi_awvalid <= 1'b0;
        i_s_axi_wvalid <= 1'b0;
        do @(posedge i_ref_clk); while (o_s_axi_bvalid !== 1'b1);
        chk({30'h0, o_s_axi_bresp}, {30'h0, er}, "write response");
    endtask

    // one read: hold araddr until arready is seen, then take data with rready held high
    task automatic rd(input logic [8:0] a, input logic [31:0] ed, input logic [1:0] er, input string what);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        // a hang here is caught by the watchdog
        do @(posedge i_ref_clk); while (o_s_axi_arready !== 1'b1);
        i_s_axi_arvalid <= 1'b0;
        do @(posedge i_ref_clk); while (o_s_axi_rvalid !== 1'b1);
        chk(o_s_axi_rdata, ed, what);
        chk({30'h0, o_s_axi_rresp}, {30'h0, er}, "read response");
    endtask

    // one start-of-frame beat, then one edge for the active copies to settle
    task automatic sof();
        i_sof_beat <= 1'b1;
        @(posedge i_ref_clk);
        i_sof_beat <= 1'b0;
        @(posedge i_ref_clk);
    endtask

    // compare all five active copies against a table
    task automatic chk_act(input logic [31:0] e [5]);
        for (int i = 0; i < 5; i++) begin
            chk(act[i], e[i], "active copy");
        end
    endtask

    // timeout guard well past the expected run length
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        i_resetn = 1'b0;
        i_ce = 1'b1;
        i_sof_beat = 1'b0;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} = 3'h0;
        {i_s_axi_bready, i_s_axi_rready} = 2'h3;
        i_s_axi_awaddr = 9'h000;
        i_s_axi_araddr = 9'h000;
        i_s_axi_wdata = 32'h0;
        i_s_axi_wstrb = 4'hF;
        i_core_state = 32'h0000_00A5;
        i_fault_set = 32'h0;
        i_diag_0 = 32'h1111_0001;
        i_diag_1 = 32'h2222_0002;
        i_diag_2 = 32'h3333_0003;
        repeat (16) @(posedge i_ref_clk);
        i_resetn <= 1'b1;
        @(posedge i_ref_clk);
        // reset values of the bank
        rd(EDG_OFF_CONTROL, EDG_CONTROL_RST, EDG_RESP_OKAY, "control");
        rd(EDG_OFF_MASK, EDG_MASK_RST, EDG_RESP_OKAY, "mask");
        rd(EDG_OFF_REVISION, EDG_REVISION_VAL, EDG_RESP_OKAY, "revision");
        for (int i = 0; i < 5; i++) rd(offs[i], EDG_DBUF_RST, EDG_RESP_OKAY, "shadow");
        chk_act(zer);
        chk({31'h0, o_core_enable}, 32'h0, "enable");
        $display("test reset_values finished");
        // address map: unmapped, read-only and input-fed registers
        rd(9'h024, 32'h0, EDG_RESP_SLVERR, "unmapped");
        wr(9'h024, 32'hFFFF_FFFF, 4'hF, EDG_RESP_SLVERR);
        wr(EDG_OFF_REVISION, 32'h5A5A_5A5A, 4'hF, EDG_RESP_OKAY);
        rd(EDG_OFF_REVISION, EDG_REVISION_VAL, EDG_RESP_OKAY, "revision");
        rd(EDG_OFF_STATE, 32'h0000_00A5, EDG_RESP_OKAY, "state");
        rd(EDG_OFF_DIAG0, 32'h1111_0001, EDG_RESP_OKAY, "diag0");
        rd(EDG_OFF_DIAG1, 32'h2222_0002, EDG_RESP_OKAY, "diag1");
        rd(EDG_OFF_DIAG2, 32'h3333_0003, EDG_RESP_OKAY, "diag2");
        wr(EDG_OFF_MASK, 32'h0000_0005, 4'hF, EDG_RESP_OKAY);
        rd(EDG_OFF_MASK, 32'h0000_0005, EDG_RESP_OKAY, "mask");
        $display("test address_map finished");
        // commit flag cleared: shadows take writes, frame start changes nothing
        wr(EDG_OFF_CONTROL, 32'h0000_0001, 4'hF, EDG_RESP_OKAY);
        chk({31'h0, o_core_enable}, 32'h1, "enable");
        for (int i = 0; i < 5; i++) wr(offs[i], vals[i], 4'hF, EDG_RESP_OKAY);
        for (int i = 0; i < 5; i++) rd(offs[i], vals[i], EDG_RESP_OKAY, "shadow");
        chk_act(zer);
        sof();
        chk_act(zer);
        $display("test commit_blocked finished");
        // commit flag set: all pending values go active at one frame start
        wr(EDG_OFF_CONTROL, 32'h0000_0003, 4'hF, EDG_RESP_OKAY);
        repeat (3) @(posedge i_ref_clk);
        chk_act(zer);
        sof();
        chk_act(vals);
        $display("test commit_together finished");
        // partial strobe write while committing: shadow reads new, active keeps old until frame start
        wr(EDG_OFF_GAIN_H, 32'hAABB_CCDD, 4'h3, EDG_RESP_OKAY);
        rd(EDG_OFF_GAIN_H, 32'h0000_CCDD, EDG_RESP_OKAY, "merged shadow");
        chk(act[1], vals[1], "active before frame");
        // a frame start seen with the clock enable low must not be taken
        i_ce <= 1'b0;
        sof();
        chk(act[1], vals[1], "active with enable low");
        i_ce <= 1'b1;
        sof();
        chk(act[1], 32'h0000_CCDD, "active after frame");
        $display("test shadow_read finished");
        // sticky fault bit set by the core, cleared by writing one
        i_fault_set <= 32'h0000_0004;
        @(posedge i_ref_clk);
        i_fault_set <= 32'h0;
        rd(EDG_OFF_FAULT, 32'h0000_0004, EDG_RESP_OKAY, "fault set");
        wr(EDG_OFF_FAULT, 32'h0000_0004, 4'hF, EDG_RESP_OKAY);
        rd(EDG_OFF_FAULT, 32'h0, EDG_RESP_OKAY, "fault cleared");
        $display("test fault_bits finished");
        // soft reset restores registers and blocks commit until cleared
        wr(EDG_OFF_CONTROL, 32'h4000_0003, 4'hF, EDG_RESP_OKAY);
        chk({31'h0, o_soft_reset}, 32'h1, "soft reset out");
        rd(EDG_OFF_CONTROL, 32'h4000_0002, EDG_RESP_OKAY, "control");
        rd(EDG_OFF_MASK, 32'h0, EDG_RESP_OKAY, "mask");
        for (int i = 0; i < 5; i++) rd(offs[i], 32'h0, EDG_RESP_OKAY, "shadow");
        chk_act(zer);
        sof();
        chk_act(zer);
        wr(EDG_OFF_CONTROL, 32'h0000_0002, 4'hF, EDG_RESP_OKAY);
        chk({31'h0, o_soft_reset}, 32'h0, "soft reset out");
        $display("test soft_reset finished");
        conclude();
    end
endmodule
